// file: shared/pca_pkg.sv
// pca_pkg: constants, register map and types for the pulse channel arbiter
// assumes a 32-bit avalon-mm slave with word addressing in bytes
package pca_pkg;
    localparam int unsigned CLK_HZ       = 20_000_000;     // system clock rate
    localparam int unsigned NUM_CH       = 4;              // pulse channels
    localparam int unsigned PLAIN_CH     = 2;              // channels with plain counters
    // register byte offsets
    localparam logic [7:0] OFS_CMD       = 8'h00;          // command launch (write)
    localparam logic [7:0] OFS_CTRL      = 8'h04;          // run enable + stop relays
    localparam logic [7:0] OFS_STATUS    = 8'h08;          // busy flags, amp power, done
    localparam logic [7:0] OFS_IRQ_ST    = 8'h0C;          // sticky events, w1c
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;          // event mask
    localparam logic [7:0] OFS_RATE      = 8'h14;          // pulse half-period in clocks, less one
    localparam logic [7:0] OFS_RAMP      = 8'h18;          // ramp-down pulse count
    localparam logic [7:0] OFS_POS_BASE  = 8'h20;          // positioning pos, ch n at +4n
    localparam logic [7:0] OFS_PLN_BASE  = 8'h30;          // plain pos, ch n at +4n
    localparam logic [7:0] OFS_ABS_BASE  = 8'h40;          // fetched servo position
    // cmd word fields
    localparam int unsigned CMD_CH_LSB   = 0;              // channel, 2 bits
    localparam int unsigned CMD_KIND_LSB = 4;              // kind, 4 bits
    localparam int unsigned CMD_DIR_BIT  = 8;              // 1 = reverse
    localparam int unsigned CMD_CNT_LSB  = 16;             // pulse count, 16 bits
    // ctrl fields
    localparam int unsigned CTRL_RUN_LSB  = 0;             // per-channel activation level
    localparam int unsigned CTRL_STOP_LSB = 4;             // per-channel stop relay
    localparam int unsigned CTRL_ABS_BIT  = 8;             // servo fetch activation
    // status fields
    localparam int unsigned ST_BUSY_LSB  = 0;
    localparam int unsigned ST_AMP_BIT   = 4;
    localparam int unsigned ST_DONE_BIT  = 5;
    localparam int unsigned ST_ABN_BIT   = 6;
    // irq event bits: done, abnormal end, refused
    localparam int unsigned EV_DONE      = 0;
    localparam int unsigned EV_ABN       = 1;
    localparam int unsigned EV_REFUSE    = 2;
    localparam int unsigned EV_W         = 3;
    localparam logic [15:0] RATE_RST     = 16'h0014;       // 42-clock pulse period at reset
    localparam logic [15:0] RAMP_RST     = 16'h0008;       // ramp-down tail at reset
    localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;  // unmapped reads return zero

    // command kinds
    typedef enum logic [3:0] {
        PCA_K_HOME_DOG   = 4'h0,   // home_search_with_dog
        PCA_K_INT_FEED   = 4'h1,   // interrupt_fixed_feed
        PCA_K_TABLE      = 4'h2,   // table_batch_positioning
        PCA_K_ABS_FETCH  = 4'h3,   // servo_position_fetch
        PCA_K_HOME_PLAIN = 4'h4,   // home_return_plain
        PCA_K_VAR_SPEED  = 4'h5,   // variable_speed_output
        PCA_K_INCR       = 4'h6,   // incremental_drive
        PCA_K_ABS_DRIVE  = 4'h7,   // absolute_target_drive
        PCA_K_PLAIN      = 4'h8,   // plain_pulse_output
        PCA_K_RAMPED     = 4'h9    // ramped_pulse_output
    } pca_kind_t;

    // per-channel emission state, one-hot
    typedef enum logic [2:0] {
        PCA_IDLE = 3'b001,
        PCA_RUN  = 3'b010,
        PCA_RAMP = 3'b100
    } pca_state_t;
endpackage

// file: logic/pca_top.sv
// pca_top: per-channel pulse emission arbiter with busy flags, stops and
// position counters, reached over an avalon-mm slave with waitrequest.
// assumes limit inputs, servo ready and servo data are synchronous to clk_sys.
//
// Functional notes
// - no new positioning start while channel emits
// - busy channel refuses all but servo fetch
// - each fetch reads servo position once
// - dropping fetch activation powers amplifier off
// - deactivation or limit gives ramped stop
// - stop relay halts emission at once
// - 32-bit positions; plain pairs on ch0, ch1
// - no backlash compensation applied
// - done flags mean emission ended, not motor
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module pca_top
    import pca_pkg::*;
#(
    parameter int unsigned CH_N = pca_pkg::NUM_CH  // channel count
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic [CH_N-1:0]      limit_fwd,
    input  wire logic [CH_N-1:0]      limit_rev,
    input  wire logic [31:0]          servo_position,
    output logic      [CH_N-1:0]      pulse_channel,
    output logic      [CH_N-1:0]      direction,
    output logic      [CH_N-1:0]      busy_flag,
    output logic                      servo_power,
    output logic                      servo_fetch_strobe,
    output logic                      irq
);
    import pca_pkg::*;

    // byte-lane merge of a write into a 32-bit word
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // step a position by one pulse in the given direction
    function automatic logic [31:0] pos_step(input logic [31:0] p, input logic rev);
        return rev ? p - 32'h0000_0001 : p + 32'h0000_0001;
    endfunction

    // ---- registers ----
    logic [31:0]      ctrl_ff, nxt_ctrl;           // run/stop/fetch levels
    logic [15:0]      rate_ff, nxt_rate;           // pulse half-period divider
    logic [15:0]      ramp_ff, nxt_ramp;           // pulses emitted while ramping
    logic [EV_W-1:0]  ev_ff, nxt_ev;               // sticky events
    logic [EV_W-1:0]  mask_ff, nxt_mask;           // event mask
    logic             done_ff, nxt_done;           // command_done_flag
    logic             abn_ff, nxt_abn;             // command_abnormal_end_flag
    logic             amp_ff, nxt_amp;             // servo power
    logic             fetch_ff, nxt_fetch;         // one-cycle fetch strobe
    logic             abs_prev_ff, nxt_abs_prev;   // fetch activation last cycle
    logic [31:0]      abs_ff, nxt_abs;             // fetched position
    logic [31:0]      rdata_ff, nxt_rdata;         // read data register
    logic             ack_ff, nxt_ack;             // answer cycle marker
    pca_state_t       st_ff   [CH_N];              // per-channel emission state
    pca_state_t       nxt_st  [CH_N];
    logic [15:0]      left_ff [CH_N];              // pulses still to emit
    logic [15:0]      nxt_left[CH_N];
    logic [15:0]      div_ff  [CH_N];              // rate divider
    logic [15:0]      nxt_div [CH_N];
    logic [CH_N-1:0]  lvl_ff, nxt_lvl;             // pulse output level
    logic [CH_N-1:0]  dir_ff, nxt_dir;             // direction per channel
    logic [CH_N-1:0]  plain_ff, nxt_plain;         // channel runs a plain family cmd
    logic [31:0]      pos_ff  [CH_N];              // positioning position pairs
    logic [31:0]      nxt_pos [CH_N];
    logic [31:0]      pln_ff  [PLAIN_CH];          // plain pulse position pairs
    logic [31:0]      nxt_pln [PLAIN_CH];

    // ---- bus decode ----
    logic        req;                  // request pending this cycle
    logic        wr_go, rd_go;         // access completes this cycle
    logic [1:0]  cmd_ch;
    pca_kind_t   cmd_kind;
    assign req             = avs_read | avs_write;
    // answer one cycle after the request appears; waitrequest low on the second cycle
    assign avs_waitrequest = req & ~ack_ff;
    assign wr_go           = avs_write & ack_ff;
    assign rd_go           = avs_read & ack_ff;
    assign avs_readdata    = rdata_ff;
    assign cmd_ch          = avs_writedata[CMD_CH_LSB +: 2];
    assign cmd_kind        = pca_kind_t'(avs_writedata[CMD_KIND_LSB +: 4]);

    // read mux: registered so read data come from flip-flops
    always_comb begin
        nxt_rdata = RD_UNMAPPED;
        if (avs_address == OFS_CTRL) begin
            nxt_rdata = ctrl_ff;
        end else if (avs_address == OFS_STATUS) begin
            nxt_rdata[ST_BUSY_LSB +: CH_N] = busy_flag;
            nxt_rdata[ST_AMP_BIT]          = amp_ff;
            nxt_rdata[ST_DONE_BIT]         = done_ff;
            nxt_rdata[ST_ABN_BIT]          = abn_ff;
        end else if (avs_address == OFS_IRQ_ST) begin
            nxt_rdata[EV_W-1:0] = ev_ff;
        end else if (avs_address == OFS_IRQ_MASK) begin
            nxt_rdata[EV_W-1:0] = mask_ff;
        end else if (avs_address == OFS_RATE) begin
            nxt_rdata[15:0] = rate_ff;
        end else if (avs_address == OFS_RAMP) begin
            nxt_rdata[15:0] = ramp_ff;
        end else if (avs_address == OFS_ABS_BASE) begin
            nxt_rdata = abs_ff;
        end
        for (int c = 0; c < CH_N; c++) begin
            if (avs_address == OFS_POS_BASE + 8'(4*c)) begin
                nxt_rdata = pos_ff[c];
            end
        end
        for (int c = 0; c < PLAIN_CH; c++) begin
            if (avs_address == OFS_PLN_BASE + 8'(4*c)) begin
                nxt_rdata = pln_ff[c];
            end
        end
        nxt_ack = req & ~ack_ff;   // single answer per request
    end

    // ---- control, launch and channel logic ----
    always_comb begin
        logic [EV_W-1:0] ev_set;        // events raised this cycle
        logic            launch;
        logic            halt_now;
        logic            soft_stop;
        logic            tick;
        ev_set    = '0;
        launch    = 1'b0;
        halt_now  = 1'b0;
        soft_stop = 1'b0;
        tick      = 1'b0;
        nxt_ctrl  = ctrl_ff;
        nxt_rate  = rate_ff;
        nxt_ramp  = ramp_ff;
        nxt_mask  = mask_ff;
        nxt_done  = done_ff;
        nxt_abn   = abn_ff;
        nxt_amp   = amp_ff;
        nxt_fetch = 1'b0;
        nxt_abs   = abs_ff;
        nxt_abs_prev = ctrl_ff[CTRL_ABS_BIT];
        nxt_lvl   = lvl_ff;
        nxt_dir   = dir_ff;
        nxt_plain = plain_ff;
        for (int c = 0; c < CH_N; c++) begin
            nxt_st[c]   = st_ff[c];
            nxt_left[c] = left_ff[c];
            nxt_div[c]  = div_ff[c];
            nxt_pos[c]  = pos_ff[c];
        end
        for (int c = 0; c < PLAIN_CH; c++) begin
            nxt_pln[c] = pln_ff[c];
        end

        // register writes
        if (wr_go) begin
            if (avs_address == OFS_CTRL) begin
                nxt_ctrl = be_merge(ctrl_ff, avs_writedata, avs_byteenable);
            end else if (avs_address == OFS_RATE) begin
                nxt_rate = avs_writedata[15:0];
            end else if (avs_address == OFS_RAMP) begin
                nxt_ramp = avs_writedata[15:0];
            end else if (avs_address == OFS_IRQ_MASK) begin
                nxt_mask = avs_writedata[EV_W-1:0];
            end
        end

        // servo fetch: power follows activation, one read per rising activation
        if (ctrl_ff[CTRL_ABS_BIT] & ~abs_prev_ff) begin
            nxt_amp   = 1'b1;
            nxt_fetch = 1'b1;
            nxt_abs   = servo_position;
        end else if (~ctrl_ff[CTRL_ABS_BIT]) begin
            nxt_amp   = 1'b0;
        end

        // command launch; the fetch kind is never blocked by busy
        if (wr_go && avs_address == OFS_CMD && cmd_kind != PCA_K_ABS_FETCH) begin
            if (32'(cmd_ch) < CH_N && st_ff[cmd_ch] == PCA_IDLE
                && ctrl_ff[CTRL_RUN_LSB + 32'(cmd_ch)]
                && ~ctrl_ff[CTRL_STOP_LSB + 32'(cmd_ch)]) begin
                launch = 1'b1;
            end else begin
                ev_set[EV_REFUSE] = 1'b1;
            end
        end
        if (launch) begin
            nxt_st[cmd_ch]    = PCA_RUN;
            nxt_left[cmd_ch]  = avs_writedata[CMD_CNT_LSB +: 16];
            nxt_div[cmd_ch]   = '0;
            nxt_dir[cmd_ch]   = avs_writedata[CMD_DIR_BIT];
            nxt_plain[cmd_ch] = (cmd_kind == PCA_K_PLAIN) || (cmd_kind == PCA_K_RAMPED);
            nxt_done = 1'b0;
            nxt_abn  = 1'b0;
        end

        // per-channel emission
        for (int c = 0; c < CH_N; c++) begin
            halt_now  = ctrl_ff[CTRL_STOP_LSB + c];
            soft_stop = ~ctrl_ff[CTRL_RUN_LSB + c]
                        | (dir_ff[c] ? limit_rev[c] : limit_fwd[c]);
            tick      = (div_ff[c] == rate_ff);
            if (st_ff[c] != PCA_IDLE && !(launch && 32'(cmd_ch) == c)) begin
                nxt_div[c] = tick ? 16'h0000 : div_ff[c] + 16'h0001;
                if (halt_now) begin
                    nxt_st[c]  = PCA_IDLE;
                    nxt_lvl[c] = 1'b0;
                    nxt_abn    = 1'b1;
                    ev_set[EV_ABN] = 1'b1;
                end else if (st_ff[c] == PCA_RUN && soft_stop) begin
                    nxt_st[c]   = PCA_RAMP;
                    nxt_left[c] = (left_ff[c] < ramp_ff) ? left_ff[c] : ramp_ff;
                end else if (left_ff[c] == 16'h0000 && !lvl_ff[c]) begin
                    nxt_st[c] = PCA_IDLE;
                    nxt_done  = 1'b1;
                    ev_set[EV_DONE] = 1'b1;
                end else if (tick) begin
                    nxt_lvl[c] = ~lvl_ff[c];
                    if (!lvl_ff[c]) begin
                        // rising edge: one pulse emitted, counted in its family (plain on ch0, ch1; plain on ch2, ch3 counts in the positioning pair)
                        nxt_left[c] = left_ff[c] - 16'h0001;
                        if (plain_ff[c] && c < PLAIN_CH) begin
                            nxt_pln[c] = pos_step(pln_ff[c], dir_ff[c]);
                        end else begin
                            nxt_pos[c] = pos_step(pos_ff[c], dir_ff[c]);
                        end
                    end
                end
            end
        end

        // sticky events: set wins over write-one-to-clear
        nxt_ev = ev_ff;
        if (wr_go && avs_address == OFS_IRQ_ST) begin
            nxt_ev = ev_ff & ~avs_writedata[EV_W-1:0];
        end
        nxt_ev = nxt_ev | ev_set;
    end

    // register stage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_ff     <= '0;
            rate_ff     <= RATE_RST;
            ramp_ff     <= RAMP_RST;
            ev_ff       <= '0;
            mask_ff     <= '0;
            done_ff     <= 1'b0;
            abn_ff      <= 1'b0;
            amp_ff      <= 1'b0;
            fetch_ff    <= 1'b0;
            abs_prev_ff <= 1'b0;
            abs_ff      <= '0;
            rdata_ff    <= '0;
            ack_ff      <= 1'b0;
            lvl_ff      <= '0;
            dir_ff      <= '0;
            plain_ff    <= '0;
            for (int c = 0; c < CH_N; c++) begin
                st_ff[c]   <= PCA_IDLE;
                left_ff[c] <= '0;
                div_ff[c]  <= '0;
                pos_ff[c]  <= '0;
            end
            for (int c = 0; c < PLAIN_CH; c++) begin
                pln_ff[c] <= '0;
            end
        end else begin
            ctrl_ff     <= nxt_ctrl;
            rate_ff     <= nxt_rate;
            ramp_ff     <= nxt_ramp;
            ev_ff       <= nxt_ev;
            mask_ff     <= nxt_mask;
            done_ff     <= nxt_done;
            abn_ff      <= nxt_abn;
            amp_ff      <= nxt_amp;
            fetch_ff    <= nxt_fetch;
            abs_prev_ff <= nxt_abs_prev;
            abs_ff      <= nxt_abs;
            rdata_ff    <= nxt_rdata;
            ack_ff      <= nxt_ack;
            lvl_ff      <= nxt_lvl;
            dir_ff      <= nxt_dir;
            plain_ff    <= nxt_plain;
            for (int c = 0; c < CH_N; c++) begin
                st_ff[c]   <= nxt_st[c];
                left_ff[c] <= nxt_left[c];
                div_ff[c]  <= nxt_div[c];
                pos_ff[c]  <= nxt_pos[c];
            end
            for (int c = 0; c < PLAIN_CH; c++) begin
                pln_ff[c] <= nxt_pln[c];
            end
        end
    end

    // outputs
    always_comb begin
        for (int c = 0; c < CH_N; c++) begin
            busy_flag[c] = (st_ff[c] != PCA_IDLE);
        end
    end
    assign pulse_channel      = lvl_ff;
    assign direction          = dir_ff;
    assign servo_power        = amp_ff;
    assign servo_fetch_strobe = fetch_ff;
    assign irq                = |(ev_ff & mask_ff);
endmodule // pca_top

// file: testbench/pca_servo_model.sv
// pca_servo_model: drive-side model, counts the pulses of one channel
// assumes pulse and direction lines are registered on clk_sys
`timescale 1ns/10ps
module pca_servo_model
    import pca_pkg::*;
#(
    parameter int unsigned TRACK_CH  = 2,  // channel wired to this drive
    parameter int unsigned READY_DLY = 40, // cycles from reset to servo ready
    parameter int unsigned SETTLE    = 8   // quiet cycles before in-position
) (
    input  wire logic [pca_pkg::NUM_CH-1:0] pulse_channel,
    input  wire logic [pca_pkg::NUM_CH-1:0] direction,
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    output logic      [31:0]                servo_position,
    output logic                            ready,
    output logic                            in_pos
);
    logic last_ff; // previous pulse level
    int   quiet, up; // cycles since the last step, since reset release
    // one step per rising edge, no play allowance
    always @(posedge clk_sys) begin
        last_ff <= rst_n && pulse_channel[TRACK_CH];
        up <= rst_n ? up + 1 : 0;
        quiet <= quiet + 1;
        if (!rst_n) begin
            servo_position <= '0;
        end else if (pulse_channel[TRACK_CH] && !last_ff) begin
            servo_position <= direction[TRACK_CH] ? servo_position - 1 : servo_position + 1;
            quiet <= 0;
        end
    end
    assign ready  = up >= READY_DLY; // ready READY_DLY cycles after reset release, whatever servo power
    assign in_pos = quiet >= SETTLE;
endmodule // pca_servo_model

// file: testbench/pca_top_chk.sv
// pca_top_chk: assertions on the ports of pca_top
// assumes one clock domain, clk_sys, with synchronous active-low rst_n
`timescale 1ns/10ps
module pca_top_chk
    import pca_pkg::*;
#(
    parameter int unsigned CH_N = pca_pkg::NUM_CH // channel count
) (
    input wire logic            clk_sys,
    input wire logic            rst_n,
    input wire logic [7:0]      avs_address,
    input wire logic            avs_read,
    input wire logic            avs_write,
    input wire logic [31:0]     avs_writedata,
    input wire logic [3:0]      avs_byteenable,
    input wire logic [31:0]     avs_readdata,
    input wire logic            avs_waitrequest,
    input wire logic [CH_N-1:0] limit_fwd,
    input wire logic [CH_N-1:0] limit_rev,
    input wire logic [31:0]     servo_position,
    input wire logic [CH_N-1:0] pulse_channel,
    input wire logic [CH_N-1:0] direction,
    input wire logic [CH_N-1:0] busy_flag,
    input wire logic            servo_power,
    input wire logic            servo_fetch_strobe,
    input wire logic            irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire wr_ok = avs_write && !avs_waitrequest;                // completed write
    wire cmd0 = wr_ok && avs_address == OFS_CMD && avs_writedata[1:0] == 2'h0;
    wire ctl  = wr_ok && avs_address == OFS_CTRL && avs_byteenable[1]; // fetch lane set
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus wait longer than one cycle");
    wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    pulse_busy_a: assert property ((pulse_channel & ~busy_flag) == '0)
        else $error("pulse high on an idle channel");
    busy_start_a: assert property ($rose(busy_flag[0]) |-> $past(cmd0) || $past(cmd0, 2))
        else $error("busy rose without a launch");
    refuse_keep_a: assert property (cmd0 && busy_flag[0] |=> busy_flag[0])
        else $error("launch on busy channel disturbed it");
    stop_now_a: assert property (ctl && avs_byteenable[0] && avs_writedata[CTRL_STOP_LSB]
        && busy_flag[0] |-> ##[1:2] !busy_flag[0] && !pulse_channel[0])
        else $error("stop relay did not halt at once");
    fetch_once_a: assert property (servo_fetch_strobe |=> !servo_fetch_strobe)
        else $error("fetch strobe longer than one cycle");
    fetch_go_a: assert property (ctl && avs_writedata[CTRL_ABS_BIT] && !servo_power
        |-> ##[1:3] servo_fetch_strobe && servo_power)
        else $error("fetch activation gave no strobe");
    power_off_a: assert property (ctl && !avs_writedata[CTRL_ABS_BIT] |-> ##[1:3] !servo_power)
        else $error("amplifier left powered");
    dir_hold_a: assert property (busy_flag[2] && $past(busy_flag[2]) |-> $stable(direction[2]))
        else $error("direction changed within a command");
    mask_off_a: assert property (wr_ok && avs_address == OFS_IRQ_MASK && avs_writedata[2:0] == 3'h0
        |=> !irq)
        else $error("irq high with all events masked");
endmodule // pca_top_chk
bind pca_top pca_top_chk #(.CH_N(CH_N)) u_chk (.clk_sys, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .limit_fwd,
    .limit_rev, .servo_position, .pulse_channel, .direction, .busy_flag, .servo_power,
    .servo_fetch_strobe, .irq);

// file: testbench/pulse_channel_arbitration_test.sv
// pulse_channel_arbitration_test: self-checking bench for pca_top
// assumes the servo model tracks channel 2 and a 20 MHz clock
`timescale 1ns/10ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module pulse_channel_arbitration_test;
    import pca_pkg::*;
    typedef struct { logic [7:0] a; logic [31:0] e; } pca_row_t; // address, expected word
    logic        clk_sys, rst_n, avs_read, avs_write;   // clock, reset, bus strobes
    logic [7:0]  avs_address;                           // byte address
    logic [31:0] avs_writedata, avs_readdata, q;         // bus data, last read
    logic [3:0]  avs_byteenable, limit_fwd, limit_rev;   // lanes, limit switches
    logic [3:0]  pulse_channel, direction, busy_flag;    // pulse side
    logic [31:0] servo_position;                        // drive encoder word
    logic        avs_waitrequest, servo_power, servo_fetch_strobe, irq, srv_ready, srv_in_pos;
    int          num_errors = 0, n_compared = 0, cyc = 0; // counters
    pca_row_t    rows [8];                              // reset value table
    pca_top #(.CH_N(NUM_CH)) u_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .limit_fwd,
        .limit_rev, .servo_position, .pulse_channel, .direction, .busy_flag, .servo_power,
        .servo_fetch_strobe, .irq);
    pca_servo_model #(.TRACK_CH(2)) u_srv (.clk_sys, .rst_n, .pulse_channel, .direction,
        .servo_position, .ready(srv_ready), .in_pos(srv_in_pos));
    // free-running system clock, 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // watchdog, far above the run length
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one avalon access; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do begin @(posedge clk_sys); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        `CHK(n < 50, 1'b1, "bus hang")
    endtask
    task automatic launch(input logic [1:0] ch, input pca_kind_t k, input logic dr,
                          input logic [15:0] cnt);
        bus(1'b1, OFS_CMD, {cnt, 7'h00, dr, k, 2'b00, ch});
    endtask
    // bounded wait for a busy level, then compare it
    task automatic wait_busy(input int ch, input logic lvl, input int lim);
        for (int n = 0; n < lim && busy_flag[ch] !== lvl; n++) @(posedge clk_sys);
        `CHK(busy_flag[ch], lvl, "busy level")
    endtask
    initial begin
        {rst_n, avs_read, avs_write, avs_address, avs_writedata, limit_fwd, limit_rev} = '0;
        avs_byteenable = 4'hF;
        rows = '{'{OFS_STATUS, 32'h0}, '{OFS_IRQ_ST, 32'h0}, '{OFS_IRQ_MASK, 32'h0},
                 '{OFS_RATE, 32'h14}, '{OFS_RAMP, 32'h8}, '{OFS_POS_BASE, 32'h0},
                 '{OFS_PLN_BASE, 32'h0}, '{8'h7C, 32'h0}};
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            bus(1'b0, rows[i].a, 32'h0);
            `CHK(q, rows[i].e, "reset word")
        end
        $display("test reset values done");
        bus(1'b1, OFS_RATE, 32'h1);
        bus(1'b1, OFS_RAMP, 32'h2);
        bus(1'b1, OFS_CTRL, 32'hF);
        launch(2, PCA_K_INCR, 1'b0, 16'h5);
        wait_busy(2, 1'b1, 8);
        wait_busy(2, 1'b0, 200);
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(q[ST_DONE_BIT], 1'b1, "done flag")
        repeat (2) @(posedge clk_sys);
        launch(2, PCA_K_INCR, 1'b1, 16'h3);
        wait_busy(2, 1'b1, 8);
        wait_busy(2, 1'b0, 200);
        bus(1'b0, OFS_POS_BASE + 8'h08, 32'h0);
        `CHK(q, 32'h2, "ch2 position")
        `CHK(servo_position, 32'h2, "drive step count")
        for (int n = 0; n < 20 && srv_in_pos !== 1'b1; n++) @(posedge clk_sys);
        `CHK(srv_in_pos, 1'b1, "drive in position")
        $display("test move and reverse done");
        `CHK(srv_ready, 1'b1, "amplifier ready")
        bus(1'b1, OFS_CTRL, 32'h10F);
        repeat (2) @(posedge clk_sys);
        `CHK(servo_fetch_strobe & servo_power, 1'b1, "fetch strobe")
        bus(1'b0, OFS_ABS_BASE, 32'h0);
        `CHK(q, 32'h2, "fetched position")
        bus(1'b1, OFS_CTRL, 32'hF);
        repeat (3) @(posedge clk_sys);
        `CHK(servo_power, 1'b0, "amplifier off")
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        @(posedge clk_sys);
        `CHK(irq, 1'b1, "irq raised")
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        @(posedge clk_sys);
        `CHK(irq, 1'b0, "irq masked")
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        bus(1'b1, OFS_IRQ_ST, 32'h7);
        @(posedge clk_sys);
        `CHK(irq, 1'b0, "irq cleared")
        $display("test fetch and irq done");
        launch(0, PCA_K_PLAIN, 1'b0, 16'd1000);
        wait_busy(0, 1'b1, 8);
        launch(0, PCA_K_RAMPED, 1'b0, 16'h4);
        bus(1'b0, OFS_IRQ_ST, 32'h0);
        `CHK(q[EV_REFUSE], 1'b1, "plain refused when busy")
        bus(1'b1, OFS_CTRL, 32'h1F);
        wait_busy(0, 1'b0, 3);
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(q[ST_ABN_BIT], 1'b1, "abnormal end")
        launch(1, PCA_K_RAMPED, 1'b0, 16'h3);
        wait_busy(1, 1'b1, 8);
        wait_busy(1, 1'b0, 200);
        bus(1'b0, OFS_PLN_BASE + 8'h04, 32'h0);
        `CHK(q, 32'h3, "plain position ch1")
        bus(1'b0, OFS_POS_BASE + 8'h04, 32'h0);
        `CHK(q, 32'h0, "positioning pair untouched")
        $display("test stop relay done");
        for (int ch = 2; ch < 4; ch++) begin
            bus(1'b1, OFS_IRQ_ST, 32'h7);
            launch(ch, PCA_K_INCR, 1'b0, 16'd1000);
            wait_busy(ch, 1'b1, 8);
            launch(ch, PCA_K_ABS_DRIVE, 1'b0, 16'h1);
            bus(1'b0, OFS_IRQ_ST, 32'h0);
            `CHK(q[EV_REFUSE], 1'b1, "positioning refused when busy")
            if (ch == 2) bus(1'b1, OFS_CTRL, 32'h1B);
            else limit_fwd[ch] <= 1'b1;
            wait_busy(ch, 1'b0, 16);
            bus(1'b0, OFS_STATUS, 32'h0);
            `CHK(q[ST_DONE_BIT], 1'b1, "ramped stop done")
        end
        limit_fwd <= 4'h0;
        bus(1'b0, 8'h38, 32'h0);
        `CHK(q, 32'h0, "no plain pair on ch2")
        $display("test ramped stops done");
        test_done();
    end
endmodule // pulse_channel_arbitration_test
